// File: inc/txenc_pkg.sv
// ****************************************
// Shared constants and types
// ****************************************
package txenc_pkg;

  localparam int         DATA_W      = 32;
  localparam int         HALF_W      = 16;
  localparam int         SYM_W       = 10;
  localparam int         FRAME_W     = 20;
  localparam int         SYMS_W      = 40;
  localparam int         CTRL_W      = 14;
  localparam int         ADDR_W      = 8;

  // Rates of the link
  localparam int         MASTER_MHZ  = 40;
  localparam int         FAST_MHZ    = 80;
  localparam int         FAST_MBPS   = 1600;
  localparam int         SLOW_MBPS   = 800;

  // 8B/10B byte values
  localparam logic [7:0] K28_5       = 8'hBC;
  localparam logic [7:0] K23_7       = 8'hF7;
  localparam logic [7:0] K30_7       = 8'hFE;
  localparam logic [7:0] D5_6        = 8'hC5;
  localparam logic [7:0] D16_2       = 8'h50;
  localparam logic [5:0] K28_SIX     = 6'h0F;
  localparam logic [3:0] ALT7_FOUR   = 4'h7;

  // Conditional invert frame fields
  localparam logic [1:0]  CF_DATA          = 2'h2;
  localparam logic [1:0]  CF_CTRL          = 2'h1;
  localparam logic [19:0] FILL_SYMBOL_ZERO = 20'hF_F0C0;
  localparam logic [19:0] FILL_SYMBOL_ONE  = 20'hF_E0E0;

  // Register map
  localparam logic [7:0]  CTRL_OFFS    = 8'h00;
  localparam logic [7:0]  STATUS_OFFS  = 8'h04;
  localparam logic [7:0]  FRAMES_OFFS  = 8'h08;
  localparam int          CTRL_ON_BIT  = 0;
  localparam logic        CTRL_ON_RST  = 1'b1;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [2:0] {
    FR_IDLE = 3'h0,
    FR_DATA = 3'h1,
    FR_CTRL = 3'h2,
    FR_EXT  = 3'h3,
    FR_ERR  = 3'h4
  } frame_kind_t;

  typedef struct packed {
    logic [31:0] din;
    logic [1:0]  flag;
    logic        dav;
    logic        cav;
    logic        fill_select;
  } tx_in_t;

  typedef struct packed {
    logic [23:0] rsvd;
    frame_kind_t kind;
    logic        ready;
    logic        fast;
    logic        cond_invert;
    logic        link_ready;
    logic        disparity;
  } status_t;

endpackage

// File: core/tx_encoder.sv
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module tx_encoder #(
  parameter int ADDR_W = txenc_pkg::ADDR_W
) (
  input  wire logic                          CLK,
  input  wire logic                          RST_N,
  input  wire logic [txenc_pkg::DATA_W-1:0]  DIN,
  input  wire logic [1:0]                    FLAG,
  input  wire logic                          DATA_VALID,
  input  wire logic                          CONTROL_VALID,
  input  wire logic                          FILL_SELECT,
  input  wire logic                          CONDITIONAL_INVERT_CODING,
  input  wire logic                          NARROW_WIDTH_PIN,
  input  wire logic                          LINK_READY,
  output logic      [txenc_pkg::SYMS_W-1:0]  TX_SYMBOLS,
  output logic                               TX_NARROW,
  input  wire logic [ADDR_W-1:0]             S_AXI_AWADDR,
  input  wire logic                          S_AXI_AWVALID,
  output logic                               S_AXI_AWREADY,
  input  wire logic [31:0]                   S_AXI_WDATA,
  input  wire logic [3:0]                    S_AXI_WSTRB,
  input  wire logic                          S_AXI_WVALID,
  output logic                               S_AXI_WREADY,
  output logic      [1:0]                    S_AXI_BRESP,
  output logic                               S_AXI_BVALID,
  input  wire logic                          S_AXI_BREADY,
  input  wire logic [ADDR_W-1:0]             S_AXI_ARADDR,
  input  wire logic                          S_AXI_ARVALID,
  output logic                               S_AXI_ARREADY,
  output logic      [31:0]                   S_AXI_RDATA,
  output logic      [1:0]                    S_AXI_RRESP,
  output logic                               S_AXI_RVALID,
  input  wire logic                          S_AXI_RREADY
);

  // ****************************************
  // 8B/10B byte coder
  // ****************************************
  function automatic logic [5:0] six_of(input logic [4:0] x);
    logic [5:0] s;
    s = 6'h00;
    unique case (x)
      5'h00: s = 6'h27;  5'h01: s = 6'h1D;  5'h02: s = 6'h2D;  5'h03: s = 6'h31;
      5'h04: s = 6'h35;  5'h05: s = 6'h29;  5'h06: s = 6'h19;  5'h07: s = 6'h38;
      5'h08: s = 6'h39;  5'h09: s = 6'h25;  5'h0A: s = 6'h15;  5'h0B: s = 6'h34;
      5'h0C: s = 6'h0D;  5'h0D: s = 6'h2C;  5'h0E: s = 6'h1C;  5'h0F: s = 6'h17;
      5'h10: s = 6'h1B;  5'h11: s = 6'h23;  5'h12: s = 6'h13;  5'h13: s = 6'h32;
      5'h14: s = 6'h0B;  5'h15: s = 6'h2A;  5'h16: s = 6'h1A;  5'h17: s = 6'h3A;
      5'h18: s = 6'h33;  5'h19: s = 6'h26;  5'h1A: s = 6'h16;  5'h1B: s = 6'h36;
      5'h1C: s = 6'h0E;  5'h1D: s = 6'h2E;  5'h1E: s = 6'h1E;  5'h1F: s = 6'h2B;
    endcase
    return s;
  endfunction

  function automatic logic [3:0] four_of(input logic [2:0] y);
    logic [3:0] f;
    f = 4'h0;
    unique case (y)
      3'h0: f = 4'hB;  3'h1: f = 4'h9;  3'h2: f = 4'h5;  3'h3: f = 4'hC;
      3'h4: f = 4'hD;  3'h5: f = 4'hA;  3'h6: f = 4'h6;  3'h7: f = 4'hE;
    endcase
    return f;
  endfunction

  // Returns {disparity out, abcdei fghj}; bit 9 leaves first
  function automatic logic [10:0] enc_byte(input logic [7:0] b, input logic k, input logic rd);
    logic [5:0] six;
    logic [3:0] four;
    logic       rd1;
    logic       rd2;
    logic [4:0] x;
    logic [2:0] y;
    x    = b[4:0];
    y    = b[7:5];
    six  = (k && x == 5'h1C) ? txenc_pkg::K28_SIX : six_of(x);
    if (rd && ($countones(six) != 3 || x == 5'h07)) begin
      six = ~six;
    end
    rd1  = rd ^ ($countones(six) != 3);
    four = four_of(y);
    // Alternate x.7 avoids a run of five on the line
    if (y == 3'h7 && (k || (!rd1 && (x == 5'h11 || x == 5'h12 || x == 5'h14))
        || (rd1 && (x == 5'h0B || x == 5'h0D || x == 5'h0E)))) begin
      four = txenc_pkg::ALT7_FOUR;
    end
    // Four-bit polarity
    // K28 flips a neutral tail too, or K28.5 would lose its comma pattern
    if ((rd1 && (y == 3'h0 || y == 3'h3 || y == 3'h4 || y == 3'h7))
        || (k && x == 5'h1C && !rd1 && !(y == 3'h0 || y == 3'h3 || y == 3'h4 || y == 3'h7))) begin
      four = ~four;
    end
    rd2  = rd1 ^ ($countones(four) != 2);
    return {rd2, six, four};
  endfunction

  // ****************************************
  // Conditional invert frame coder
  // ****************************************
  // Returns {disparity out, frame}; frame bits 9:0 leave first
  function automatic logic [20:0] conditional_invert_coding_frame(input logic [15:0] payload, input logic flag,
                                              input logic [1:0] cfield, input logic rd);
    logic [16:0] body;
    logic        inv;
    logic [19:0] fr;
    logic [4:0]  ones;
    body = {flag, payload};
    ones = 5'($countones(body));
    // Invert a heavy word at high disparity or a light word at low, either of which would push disparity further
    inv  = (rd && ones > 5'd8) || (!rd && ones < 5'd9);
    if (inv) begin
      body = ~body;
    end
    fr   = {cfield, inv, body};
    ones = 5'($countones(fr));
    return {(ones > 5'd10) ? 1'b1 : ((ones < 5'd10) ? 1'b0 : rd), fr};
  endfunction

  // ****************************************
  // Software registers
  // ****************************************
  logic                   tx_on_q;
  logic [15:0]            frames_q;
  logic                   rd_q;
  txenc_pkg::frame_kind_t kind_q;
  txenc_pkg::status_t     status;
  logic                   ready;

  logic [ADDR_W-1:0]      awaddr_q;
  logic                   aw_have_q;
  logic [31:0]            wdata_q;
  logic [3:0]             wstrb_q;
  logic                   w_have_q;
  logic                   wr_go;
  logic                   frames_clr;

  // Idle until lock and software enable
  assign ready  = LINK_READY & tx_on_q;
  assign wr_go  = aw_have_q & w_have_q & ~S_AXI_BVALID;
  assign frames_clr = wr_go && awaddr_q[7:0] == txenc_pkg::FRAMES_OFFS;

  always_comb begin
    status             = '0;
    status.kind        = kind_q;
    status.ready       = ready;
    status.fast        = ~NARROW_WIDTH_PIN;
    status.cond_invert = CONDITIONAL_INVERT_CODING;
    status.link_ready  = LINK_READY;
    status.disparity   = rd_q;
  end

  // Write address and data, either order
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      S_AXI_AWREADY <= 1'b0;
      aw_have_q     <= 1'b0;
      awaddr_q      <= '0;
    end else begin
      S_AXI_AWREADY <= !S_AXI_AWREADY && S_AXI_AWVALID && !aw_have_q && !S_AXI_BVALID;
      if (S_AXI_AWREADY && S_AXI_AWVALID) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= S_AXI_AWADDR;
      end else if (wr_go) begin
        aw_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      S_AXI_WREADY <= 1'b0;
      w_have_q     <= 1'b0;
      wdata_q      <= '0;
      wstrb_q      <= '0;
    end else begin
      S_AXI_WREADY <= !S_AXI_WREADY && S_AXI_WVALID && !w_have_q && !S_AXI_BVALID;
      if (S_AXI_WREADY && S_AXI_WVALID) begin
        w_have_q <= 1'b1;
        wdata_q  <= S_AXI_WDATA;
        wstrb_q  <= S_AXI_WSTRB;
      end else if (wr_go) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Register write and response
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tx_on_q      <= txenc_pkg::CTRL_ON_RST;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= txenc_pkg::RESP_OKAY;
    end else if (wr_go) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= txenc_pkg::RESP_OKAY;
      if (awaddr_q[7:0] == txenc_pkg::CTRL_OFFS) begin
        if (wstrb_q[0]) begin
          tx_on_q <= wdata_q[txenc_pkg::CTRL_ON_BIT];
        end
      end else if (awaddr_q[7:0] != txenc_pkg::STATUS_OFFS && !frames_clr) begin
        S_AXI_BRESP <= txenc_pkg::RESP_SLVERR;
      end
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Register read
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= '0;
      S_AXI_RRESP   <= txenc_pkg::RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= !S_AXI_ARREADY && S_AXI_ARVALID && !S_AXI_RVALID;
      if (S_AXI_ARREADY && S_AXI_ARVALID) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP  <= txenc_pkg::RESP_OKAY;
        unique case (S_AXI_ARADDR[7:0])
          txenc_pkg::CTRL_OFFS:   S_AXI_RDATA <= {31'h0000_0000, tx_on_q};
          txenc_pkg::STATUS_OFFS: S_AXI_RDATA <= status;
          txenc_pkg::FRAMES_OFFS: S_AXI_RDATA <= {16'h0000, frames_q};
          default: begin
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= txenc_pkg::RESP_SLVERR;
          end
        endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // ****************************************
  // Frame selection and coding
  // ****************************************
  txenc_pkg::tx_in_t      in_w;
  txenc_pkg::frame_kind_t kind_d;
  logic [txenc_pkg::SYMS_W-1:0] sym_d;
  logic                   rd_d;

  assign in_w = '{din: DIN, flag: FLAG, dav: DATA_VALID, cav: CONTROL_VALID,
                  fill_select: FILL_SELECT};

  always_comb begin
    kind_d = txenc_pkg::FR_IDLE;
    if (ready) begin
      if (CONDITIONAL_INVERT_CODING) begin
        if (in_w.cav) begin
          kind_d = txenc_pkg::FR_CTRL;
        end else if (in_w.dav) begin
          kind_d = txenc_pkg::FR_DATA;
        end
      end else begin
        unique case ({in_w.cav, in_w.dav})
          2'b01:   kind_d = txenc_pkg::FR_DATA;
          2'b10:   kind_d = txenc_pkg::FR_EXT;
          2'b11:   kind_d = txenc_pkg::FR_ERR;
          default: kind_d = txenc_pkg::FR_IDLE;
        endcase
      end
    end
  end

  always_comb begin
    logic [20:0]  cf;
    logic [10:0]  e0;
    logic [10:0]  e1;
    logic [15:0]  half;
    logic [7:0]   b0;
    logic [7:0]   b1;
    logic         k0;
    logic         k1;
    logic         rd;
    logic [19:0]  word;
    cf    = '0;
    e0    = '0;
    e1    = '0;
    half  = '0;
    b0    = '0;
    b1    = '0;
    k0    = 1'b0;
    k1    = 1'b0;
    word  = '0;
    rd    = rd_q;
    sym_d = '0;
    // Slow mode codes one half only
    for (int h = 0; h < 2; h++) begin
      if (h == 0 || !NARROW_WIDTH_PIN) begin
        half = in_w.din[h*txenc_pkg::HALF_W +: txenc_pkg::HALF_W];
        if (CONDITIONAL_INVERT_CODING) begin
          unique case (kind_d)
            txenc_pkg::FR_DATA: begin
              cf   = conditional_invert_coding_frame(half, in_w.flag[h], txenc_pkg::CF_DATA, rd);
              word = cf[19:0];
              rd   = cf[20];
            end
            txenc_pkg::FR_CTRL: begin
              cf   = conditional_invert_coding_frame({2'b00, half[txenc_pkg::CTRL_W-1:0]}, 1'b0, txenc_pkg::CF_CTRL, rd);
              word = cf[19:0];
              rd   = cf[20];
            end
            default: begin
              word = in_w.fill_select ? txenc_pkg::FILL_SYMBOL_ONE : txenc_pkg::FILL_SYMBOL_ZERO;
            end
          endcase
        end else begin
          unique case (kind_d)
            txenc_pkg::FR_DATA: begin
              b0 = half[7:0];
              b1 = half[15:8];
              k0 = 1'b0;
              k1 = 1'b0;
            end
            txenc_pkg::FR_EXT: begin
              b0 = txenc_pkg::K23_7;
              b1 = txenc_pkg::K23_7;
              k0 = 1'b1;
              k1 = 1'b1;
            end
            txenc_pkg::FR_ERR: begin
              b0 = txenc_pkg::K30_7;
              b1 = txenc_pkg::K30_7;
              k0 = 1'b1;
              k1 = 1'b1;
            end
            default: begin
              b0 = txenc_pkg::K28_5;
              b1 = rd ? txenc_pkg::D5_6 : txenc_pkg::D16_2;
              k0 = 1'b1;
              k1 = 1'b0;
            end
          endcase
          e0   = enc_byte(b0, k0, rd);
          e1   = enc_byte(b1, k1, e0[10]);
          rd   = e1[10];
          word = {e1[9:0], e0[9:0]};
        end
        sym_d[h*txenc_pkg::FRAME_W +: txenc_pkg::FRAME_W] = word;
      end
    end
    rd_d = rd;
  end

  // ****************************************
  // Output stage
  // ****************************************
  // Whole master cycle per register load
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      TX_SYMBOLS <= '0;
      TX_NARROW  <= 1'b0;
      kind_q     <= txenc_pkg::FR_IDLE;
    end else begin
      TX_SYMBOLS <= sym_d;
      TX_NARROW  <= NARROW_WIDTH_PIN;
      kind_q     <= kind_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rd_q <= 1'b0;
    end else begin
      rd_q <= rd_d;
    end
  end

  // Clear with a frame in the same cycle loads one, so no frame is lost
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      frames_q <= '0;
    end else if (kind_d == txenc_pkg::FR_DATA) begin
      frames_q <= frames_clr ? 16'h0001 : frames_q + 16'h0001;
    end else if (frames_clr) begin
      frames_q <= '0;
    end
  end

endmodule

// File: bench/tx_encoder_sva.sv
`timescale 1ns/1ps
module tx_encoder_sva (
  input logic        CLK,
  input logic        RST_N,
  input logic [39:0] TX_SYMBOLS,
  input logic        DATA_VALID,
  input logic        CONTROL_VALID,
  input logic        FILL_SELECT,
  input logic        CONDITIONAL_INVERT_CODING,
  input logic        NARROW_WIDTH_PIN,
  input logic        LINK_READY,
  input logic        S_AXI_BVALID,
  input logic        S_AXI_BREADY
);
  // ****************
  // Line code and write response checks
  // ****************
  logic       cim;
  logic [9:0] b0;
  assign cim = CONDITIONAL_INVERT_CODING;
  assign b0  = TX_SYMBOLS[9:0];

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  AST_NARROW_UPPER:
    assert property (NARROW_WIDTH_PIN |=> TX_SYMBOLS[39:20] == 20'h0_0000)
    else $error("upper half active in narrow mode");
  AST_CONDITIONAL_INVERT_CODING_NO_DATA:
    assert property (cim && !(DATA_VALID && !CONTROL_VALID) |=> TX_SYMBOLS[19:18] != txenc_pkg::CF_DATA)
    else $error("data frame without lone data valid");
  AST_FILL_ZERO:
    assert property (cim && !DATA_VALID && !CONTROL_VALID && !FILL_SELECT
                     |=> TX_SYMBOLS[19:0] == txenc_pkg::FILL_SYMBOL_ZERO)
    else $error("fill symbol zero missing");
  AST_FILL_ONE:
    assert property (cim && !DATA_VALID && !CONTROL_VALID && FILL_SELECT
                     |=> TX_SYMBOLS[19:0] == txenc_pkg::FILL_SYMBOL_ONE)
    else $error("fill symbol one missing");
  AST_NOT_READY_FILL:
    assert property (cim && !LINK_READY && !FILL_SELECT |=> TX_SYMBOLS[19:0] == txenc_pkg::FILL_SYMBOL_ZERO)
    else $error("inputs leaked while not ready");
  AST_ETH_EXTEND:
    assert property (!cim && CONTROL_VALID && !DATA_VALID |=> b0 inside {10'h3A8, 10'h057, 10'h0FA, 10'h305})
    else $error("carrier extend code missing");
  AST_ETH_ERROR:
    assert property (!cim && CONTROL_VALID && DATA_VALID |=> b0 inside {10'h1E8, 10'h217, 10'h0FA, 10'h305})
    else $error("error propagation code missing");
  AST_ETH_IDLE:
    assert property (!cim && (!LINK_READY || (!DATA_VALID && !CONTROL_VALID)) |=> (b0 == 10'h0FA || b0 == 10'h305))
    else $error("idle does not open with comma");
  // One response per write, so a held valid is a stuck slave
  AST_WRITE_ONCE:
    assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response repeated");
endmodule

bind tx_encoder tx_encoder_sva i_tx_encoder_sva (
  .CLK(CLK),
  .RST_N(RST_N),
  .TX_SYMBOLS(TX_SYMBOLS),
  .DATA_VALID(DATA_VALID),
  .CONTROL_VALID(CONTROL_VALID),
  .FILL_SELECT(FILL_SELECT),
  .CONDITIONAL_INVERT_CODING(CONDITIONAL_INVERT_CODING),
  .NARROW_WIDTH_PIN(NARROW_WIDTH_PIN),
  .LINK_READY(LINK_READY),
  .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY)
);

// File: bench/link_rx_model.sv
`timescale 1ns/1ps
module link_rx_model (
  input  wire logic        CLK,
  input  wire logic        WATCH,
  input  wire logic        NARROW,
  input  wire logic [39:0] SYMS,
  output int               bad_cnt
);
  // ****************
  // Receiver balance monitor
  // ****************
  int disp;
  int ones;
  initial begin
    bad_cnt = 0;
    disp = 0;
  end
  always @(posedge CLK) begin
    if (!WATCH) begin
      disp = 0;
    end else begin
      for (int k = 0; k < (NARROW ? 2 : 4); k++) begin
        ones = $countones(SYMS[k*10 +: 10]);
        disp = disp + 2 * ones - 10;
        if (ones < 4 || ones > 6 || disp > 2 || disp < -2) bad_cnt++;
      end
    end
  end
endmodule

// File: bench/tb.sv
`timescale 1ns/1ps
module tb;
  // ****************
  // Bench state
  // ****************
  typedef struct packed {
    logic              cod;
    txenc_pkg::tx_in_t stim;
    logic [39:0]       exp;
  } row_t;
  row_t              rows [6];
  txenc_pkg::tx_in_t in_q;
  logic        CLK, RST_N, cod, narrow, link, watch, tx_narrow;
  logic        awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [39:0] syms;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd;
  logic [3:0]  ws;
  logic [1:0]  brs, rrs;
  int          err_total, checked, cyc, bad_cnt;

  tx_encoder i_tx_encoder (
    .CLK(CLK), .RST_N(RST_N), .DIN(in_q.din), .FLAG(in_q.flag),
    .DATA_VALID(in_q.dav), .CONTROL_VALID(in_q.cav), .FILL_SELECT(in_q.fill_select),
    .CONDITIONAL_INVERT_CODING(cod), .NARROW_WIDTH_PIN(narrow), .LINK_READY(link),
    .TX_SYMBOLS(syms), .TX_NARROW(tx_narrow),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
    .S_AXI_BRESP(brs), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rd), .S_AXI_RRESP(rrs), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr)
  );
  link_rx_model i_link_rx_model (.CLK(CLK), .WATCH(watch), .NARROW(narrow), .SYMS(syms), .bad_cnt(bad_cnt));

  // ****************
  // Compare and bus tasks
  // ****************
  task automatic chk_sym(input string n, input logic [39:0] e, input logic [39:0] s);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask

  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask

  // Invert bit is the coder's choice, so both polarities are legal
  task automatic chk_half(input logic [1:0] cf, input logic fl, input logic [15:0] p, input logic [19:0] s);
    logic [19:0] e;
    e = s[17] ? {cf, 1'b1, ~fl, ~p} : {cf, 1'b0, fl, p};
    chk_sym("half", {20'h0_0000, e}, {20'h0_0000, s});
  endtask

  task automatic send(input logic c, input txenc_pkg::tx_in_t v);
    @(posedge CLK);
    cod <= c;
    in_q <= v;
    @(posedge CLK);
    #1;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge CLK);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv && n < 50);
    br <= 1'b0;
    chk_word("bresp", {30'h0, r}, {30'h0, brs});
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r, input logic [31:0] m);
    int n;
    n = 0;
    @(posedge CLK);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
      if (arr) arv <= 1'b0;
    end while (!rv && n < 50);
    rr <= 1'b0;
    chk_word("rdata", e, rd & m);
    chk_word("rresp", {30'h0, r}, {30'h0, rrs});
  endtask

  task automatic results;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ****************
  // Clock and watchdog
  // ****************
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      results();
    end
  end

  // ****************
  // Main sequence
  // ****************
  initial begin
    {RST_N, cod, narrow, watch, in_q, awv, wv, br, arv, rr, awa, ara, wd} = '0;
    link = 1'b1;
    ws = 4'hF;
    rows[0] = {1'b0, 32'h0000_0000, 2'h0, 3'b000, {2{10'h245, 10'h0FA}}};
    rows[1] = {1'b0, 32'h0000_00B5, 2'h0, 3'b100, {3{10'h274}}, 10'h2AA};
    rows[2] = {1'b0, 32'h0000_00B5, 2'h0, 3'b010, {4{10'h3A8}}};
    rows[3] = {1'b0, 32'h0000_00B5, 2'h0, 3'b110, {4{10'h1E8}}};
    rows[4] = {1'b1, 32'h0000_00B5, 2'h3, 3'b000, {2{txenc_pkg::FILL_SYMBOL_ZERO}}};
    rows[5] = {1'b1, 32'h0000_00B5, 2'h3, 3'b001, {2{txenc_pkg::FILL_SYMBOL_ONE}}};
    repeat (3) @(posedge CLK);
    RST_N <= 1'b1;
    axi_rd(txenc_pkg::CTRL_OFFS, 32'h0000_0001, txenc_pkg::RESP_OKAY, 32'h0000_0001);
    for (int i = 0; i < 6; i++) begin
      send(rows[i].cod, rows[i].stim);
      chk_sym("row", rows[i].exp, syms);
    end
    send(1'b1, {32'h1234_5678, 2'b10, 3'b100});
    chk_half(txenc_pkg::CF_DATA, 1'b0, 16'h5678, syms[19:0]);
    chk_half(txenc_pkg::CF_DATA, 1'b1, 16'h1234, syms[39:20]);
    send(1'b1, {32'hC0DE_FFFF, 2'b01, 3'b110});
    chk_half(txenc_pkg::CF_CTRL, 1'b0, 16'h3FFF, syms[19:0]);
    chk_half(txenc_pkg::CF_CTRL, 1'b0, 16'h00DE, syms[39:20]);
    @(posedge CLK);
    link <= 1'b0;
    send(1'b1, {32'h1234_5678, 2'b11, 3'b100});
    chk_sym("conditional_invert_coding_lock", {2{txenc_pkg::FILL_SYMBOL_ZERO}}, syms);
    send(1'b0, {32'h0000_00B5, 2'h0, 3'b100});
    chk_sym("eth_lock", {2{10'h245, 10'h0FA}}, syms);
    @(posedge CLK);
    link <= 1'b1;
    axi_wr(txenc_pkg::CTRL_OFFS, 32'h0000_0000, txenc_pkg::RESP_OKAY);
    send(1'b0, {32'h0000_00B5, 2'h0, 3'b100});
    chk_sym("tx_off", {2{10'h245, 10'h0FA}}, syms);
    axi_rd(txenc_pkg::STATUS_OFFS, 32'h0000_000A, txenc_pkg::RESP_OKAY, 32'h0000_001E);
    @(posedge CLK);
    in_q <= '0;
    axi_wr(txenc_pkg::CTRL_OFFS, 32'h0000_0001, txenc_pkg::RESP_OKAY);
    axi_wr(txenc_pkg::FRAMES_OFFS, 32'h0000_0000, txenc_pkg::RESP_OKAY);
    @(posedge CLK);
    in_q.dav <= 1'b1;
    repeat (3) @(posedge CLK);
    in_q.dav <= 1'b0;
    axi_rd(txenc_pkg::FRAMES_OFFS, 32'h0000_0003, txenc_pkg::RESP_OKAY, 32'h0000_FFFF);
    axi_wr(8'h0C, 32'h0000_0001, txenc_pkg::RESP_SLVERR);
    axi_rd(8'h0C, 32'h0000_0000, txenc_pkg::RESP_SLVERR, 32'hFFFF_FFFF);
    // Unbalanced bytes mixed with error codes stress disparity
    @(posedge CLK);
    watch <= 1'b1;
    for (int i = 0; i < 64; i++) begin
      in_q <= {{4{8'(i * 37)}}, 2'h0, 1'b1, i[0], 1'b0};
      @(posedge CLK);
    end
    watch <= 1'b0;
    @(posedge CLK);
    RST_N <= 1'b0;
    narrow <= 1'b1;
    in_q <= '0;
    repeat (3) @(posedge CLK);
    RST_N <= 1'b1;
    chk_word("disp_err", 32'h0000_0000, bad_cnt);
    send(1'b0, {32'hFFFF_00B5, 2'h0, 3'b100});
    chk_sym("slow_data", {20'h0_0000, 10'h274, 10'h2AA}, syms);
    send(1'b0, {32'hFFFF_00B5, 2'h0, 3'b010});
    chk_sym("slow_ext", {20'h0_0000, {2{10'h3A8}}}, syms);
    chk_sym("narrow", 40'h00_0000_0001, {39'h0, tx_narrow});
    results();
  end
endmodule
